/* hdl/rld_chan.v */
`timescale 1ns/10ps
`include "rld_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// One receive channel: input select, decode, violation detect and count
module rld_chan #(
    parameter CW = `RLD_WIDTH_CNT
) (
    input wire clock,
    input wire rstn,
    input wire ternary_in_a,
    input wire ternary_in_b,
    input wire optical_data_in,
    input wire input_type_select,
    input wire [1:0] rx_code_field,
    input wire extended_zeros_select,
    input wire violation_compat_bit,
    input wire tuned,
    input wire cnt_clear,
    output reg rx_data_q,
    output reg viol_q,
    output reg [CW-1:0] cnt_q
);
    reg last_pol_q; // Polarity of last mark
    reg prev_mark_q; // Previous bit was a mark
    reg cmi_phase_q; // CMI half-bit phase
    reg cmi_first_q; // First CMI half-bit
    reg [2:0] zero_run_q; // Zeros since last mark
    reg pos; // Positive mark this cycle
    reg neg; // Negative mark this cycle
    reg bit_en; // Bit boundary strobe
    reg bpv; // Raw bipolar violation
    reg masked; // Violation masked by compat, or untuned with compat clear
    reg code_err; // Counted code error
    // Line input mux and CMI front end
    always @* begin
        pos = 1'b0;
        neg = 1'b0;
        bit_en = 1'b1;
        if (input_type_select && rx_code_field == `RLD_CODE_CMI) begin
            // CMI: 11/00 = mark alternating, 01 = space; route clock from half-bits
            bit_en = cmi_phase_q;
            pos = cmi_first_q & optical_data_in;
            neg = ~cmi_first_q & ~optical_data_in;
        end else if (!input_type_select) begin
            pos = ternary_in_a & ~ternary_in_b;
            neg = ternary_in_b & ~ternary_in_a;
        end
    end
    // Violation and mask logic
    always @* begin
        bpv = (pos | neg) && (pos == last_pol_q);
        // Compat mode turns a back-to-back violation into a zero
        masked = violation_compat_bit && prev_mark_q;
        if (!violation_compat_bit && !tuned)
            masked = prev_mark_q;
        code_err = 1'b0;
        case (rx_code_field)
            `RLD_CODE_AMI: code_err = bpv && !masked;
            `RLD_CODE_HDB3: code_err = bpv && !masked &&
                (extended_zeros_select ? (zero_run_q != 3'h3) : 1'b1);
            `RLD_CODE_CMI: code_err = bpv && !masked;
            default: code_err = 1'b0;
        endcase
    end
    // Decoder state and counter
    always @(posedge clock) begin
        if (!rstn) begin
            last_pol_q <= 1'b0;
            prev_mark_q <= 1'b0;
            cmi_phase_q <= 1'b0;
            cmi_first_q <= 1'b0;
            zero_run_q <= 3'h0;
            rx_data_q <= 1'b0;
            viol_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
        end else begin
            cmi_phase_q <= ~cmi_phase_q;
            if (!cmi_phase_q)
                cmi_first_q <= optical_data_in;
            viol_q <= 1'b0;
            if (cnt_clear)
                cnt_q <= {CW{1'b0}};
            if (bit_en) begin
                // NRZ passes level, others decode marks
                if (rx_code_field == `RLD_CODE_NRZ)
                    rx_data_q <= ternary_in_a;
                else
                    rx_data_q <= (pos | neg) & ~(bpv & masked);
                prev_mark_q <= pos | neg;
                if (pos | neg) begin
                    if (!(bpv && masked))
                        last_pol_q <= pos;
                    zero_run_q <= 3'h0;
                end else if (zero_run_q != 3'h7) begin
                    zero_run_q <= zero_run_q + 3'h1;
                end
                if (code_err) begin
                    viol_q <= 1'b1;
                    if (!cnt_clear)
                        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

/* hdl/rld_defines.vh */
`ifndef RLD_DEFINES_VH
`define RLD_DEFINES_VH
// Register byte offsets (word aligned)
`define RLD_OFF_CODE 8'h00
`define RLD_OFF_CLK 8'h04
`define RLD_OFF_TERM 8'h08
`define RLD_OFF_CMD 8'h0C
`define RLD_OFF_IPTR 8'h10
`define RLD_OFF_IDAT 8'h14
`define RLD_OFF_CNT0 8'h20
`define RLD_OFF_STAT 8'h30
// Receive code field encodings
`define RLD_CODE_NRZ 2'h0
`define RLD_CODE_CMI 2'h1
`define RLD_CODE_AMI 2'h2
`define RLD_CODE_HDB3 2'h3
// Tuning sequence values
`define RLD_TUNE_PTR0 8'h2C
`define RLD_TUNE_DAT0 8'hFF
`define RLD_TUNE_PEND 8'h00
// Reset value and counter width
`define RLD_COMPAT_RST 1'h1
`define RLD_WIDTH_CNT 16
`endif

/* hdl/rld_top.v */
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`include "rld_defines.vh"
// How it works
// - Cleared compat plus tuning counts single/double violations
// - Three or more consecutive marks may go uncounted
// - Compat bit resets to one, hides back-to-back violations
// - Compat one decodes a back-to-back same-polarity mark as zero
// - Sparse-mark patterns always report every violation
// - Framed all-ones reports only post-zero-framing violations
// - Receive reset discards the tuning
// - Clock select picks recovered or oscillator clock
// - Each clock pin picks any channel clock
// - Ternary input with select clear; select set gives CMI optical, no marks for AMI/HDB3
// - Code field selects HDB3/B8ZS or AMI decoding
// - Code values: 10 AMI, 11 HDB3, 00 NRZ, 01 CMI
// - CMI recovers clock, HDB3/AMI post-decode, no correction
// - Extended zeros bit picks HDB3 violation check
// - Each code error bumps a 16-bit counter; a clear in the same cycle wins
// - Without input, switches follow their own bits; analog also needs every enable bit
// - With input, switches follow bit-equals-input equations
module rld_top #(
    parameter NCH = 4,
    parameter CW = `RLD_WIDTH_CNT
) (
    input wire clock,
    input wire rstn,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [NCH-1:0] ternary_in_a,
    input wire [NCH-1:0] ternary_in_b,
    input wire [NCH-1:0] optical_data_in,
    input wire [NCH-1:0] recovered_clk_in,
    input wire [NCH-1:0] osc_clk_in,
    input wire [NCH-1:0] hw_termination_input,
    output wire [NCH-1:0] rx_data,
    output wire [NCH-1:0] rx_viol,
    output wire [NCH-1:0] rx_clock_pin,
    output reg [NCH-1:0] term_switch_on,
    output reg [NCH-1:0] analog_switch_on,
    output reg [3*NCH-1:0] osc_freq_sel
);
    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    reg ack_q; // One-cycle wait then answer
    reg [NCH-1:0] input_type_select_q;
    reg [2*NCH-1:0] rx_code_field_q;
    reg [NCH-1:0] extended_zeros_select_q;
    reg violation_compat_bit_q; // Global compat bit
    reg [3*NCH-1:0] rx_clock_source_select_q;
    reg [3*NCH-1:0] clock_pin_route_select_q;
    reg [NCH-1:0] termination_switch_bit_q;
    reg [NCH-1:0] analog_switch_bit_q;
    reg [NCH-1:0] analog_switch_enable_q;
    reg [NCH-1:0] hw_term_assign_q; // Port carrying the termination input
    reg [7:0] indirect_pointer_reg_q;
    reg [7:0] indirect_data_reg_q;
    reg tuned_q; // Tuning series completed
    reg tune_armed_q; // First step of series seen
    reg [NCH-1:0] cnt_clear_q; // Counter clear strobe
    wire [CW*NCH-1:0] cnt_w;
    wire [NCH-1:0] chan_clk;
    wire acc;
    wire wr;
    wire [3:0] be_unused;
    wire [NCH-1:0] receive_reset_cmd;
    // Wait one cycle on every access
    assign acc = (avs_read | avs_write) & ~ack_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr = avs_write & ack_q;
    assign be_unused = avs_byteenable;
    assign receive_reset_cmd = (wr && avs_address == `RLD_OFF_CMD && avs_byteenable[0]) ?
        avs_writedata[NCH-1:0] : {NCH{1'b0}};
    ////////////////////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge clock) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            input_type_select_q <= {NCH{1'b0}};
            rx_code_field_q <= {NCH{`RLD_CODE_HDB3}};
            extended_zeros_select_q <= {NCH{1'b0}};
            violation_compat_bit_q <= `RLD_COMPAT_RST;
            rx_clock_source_select_q <= {(3*NCH){1'b0}};
            clock_pin_route_select_q <= {(3*NCH){1'b0}};
            termination_switch_bit_q <= {NCH{1'b0}};
            analog_switch_bit_q <= {NCH{1'b0}};
            analog_switch_enable_q <= {NCH{1'b0}};
            hw_term_assign_q <= {NCH{1'b0}};
            indirect_pointer_reg_q <= 8'h00;
            indirect_data_reg_q <= 8'h00;
            tuned_q <= 1'b0;
            tune_armed_q <= 1'b0;
            cnt_clear_q <= {NCH{1'b0}};
        end else begin
            ack_q <= acc;
            cnt_clear_q <= {NCH{1'b0}};
            if (wr) begin
                case (avs_address)
                    `RLD_OFF_CODE: begin
                        rx_code_field_q <= avs_writedata[2*NCH-1:0];
                        input_type_select_q <= avs_writedata[8+NCH-1:8];
                        extended_zeros_select_q <= avs_writedata[16+NCH-1:16];
                        violation_compat_bit_q <= avs_writedata[24];
                    end
                    `RLD_OFF_CLK: begin
                        rx_clock_source_select_q <= avs_writedata[3*NCH-1:0];
                        clock_pin_route_select_q <= avs_writedata[16+3*NCH-1:16];
                    end
                    `RLD_OFF_TERM: begin
                        termination_switch_bit_q <= avs_writedata[NCH-1:0];
                        analog_switch_bit_q <= avs_writedata[8+NCH-1:8];
                        analog_switch_enable_q <= avs_writedata[16+NCH-1:16];
                        hw_term_assign_q <= avs_writedata[24+NCH-1:24];
                    end
                    `RLD_OFF_CMD: cnt_clear_q <= avs_writedata[8+NCH-1:8];
                    `RLD_OFF_IPTR: begin
                        indirect_pointer_reg_q <= avs_writedata[7:0];
                        // Series opens with first pointer, ends with closing pointer
                        if (avs_writedata[7:0] == `RLD_TUNE_PTR0)
                            tune_armed_q <= 1'b1;
                        else if (avs_writedata[7:0] == `RLD_TUNE_PEND && tune_armed_q) begin
                            tuned_q <= 1'b1;
                            tune_armed_q <= 1'b0;
                        end
                    end
                    `RLD_OFF_IDAT: indirect_data_reg_q <= avs_writedata[7:0];
                    default: ;
                endcase
            end
            // Any receive reset drops the shared tuning
            if (|receive_reset_cmd) begin
                tuned_q <= 1'b0;
                tune_armed_q <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Register reads; unmapped reads zero
    always @(posedge clock) begin
        if (!rstn) begin
            avs_readdata <= 32'h00000000;
        end else begin
            avs_readdata <= 32'h00000000;
            if (avs_read && !ack_q) begin
                case (avs_address)
                    `RLD_OFF_CODE: avs_readdata <= {7'h00, violation_compat_bit_q,
                        {(8-NCH){1'b0}}, extended_zeros_select_q,
                        {(8-NCH){1'b0}}, input_type_select_q,
                        {(8-2*NCH){1'b0}}, rx_code_field_q};
                    `RLD_OFF_CLK: avs_readdata <= {{(16-3*NCH){1'b0}}, clock_pin_route_select_q,
                        {(16-3*NCH){1'b0}}, rx_clock_source_select_q};
                    `RLD_OFF_TERM: avs_readdata <= {{(8-NCH){1'b0}}, hw_term_assign_q,
                        {(8-NCH){1'b0}}, analog_switch_enable_q,
                        {(8-NCH){1'b0}}, analog_switch_bit_q,
                        {(8-NCH){1'b0}}, termination_switch_bit_q};
                    `RLD_OFF_IPTR: avs_readdata <= {24'h000000, indirect_pointer_reg_q};
                    `RLD_OFF_IDAT: avs_readdata <= {24'h000000, indirect_data_reg_q};
                    `RLD_OFF_STAT: avs_readdata <= {{(24-2*NCH){1'b0}}, analog_switch_on,
                        term_switch_on, 7'h00, tuned_q};
                    default: begin
                        if (avs_address[7:4] == 4'h2 && avs_address[3:2] < NCH)
                            avs_readdata <= {{(32-CW){1'b0}},
                                cnt_w[avs_address[3:2]*CW +: CW]};
                    end
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel datapath, clocks and switches
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : ch
            wire [2:0] rs = rx_clock_source_select_q[3*g +: 3];
            wire [2:0] ps = clock_pin_route_select_q[3*g +: 3];
            wire [CW-1:0] cnt;
            // Each channel compares its bit with its own termination input pin
            wire eq = termination_switch_bit_q[g] == hw_termination_input[g];
            assign cnt_w[CW*g +: CW] = cnt;
            // Route clock or oscillator; nonzero also sets oscillator rate
            assign chan_clk[g] = (rs == 3'h0) ? recovered_clk_in[g] : osc_clk_in[g];
            assign rx_clock_pin[g] = chan_clk[ps[1:0]];
            rld_chan #(.CW(CW)) u_chan (
                .clock(clock),
                .rstn(rstn & ~receive_reset_cmd[g]),
                .ternary_in_a(ternary_in_a[g]),
                .ternary_in_b(ternary_in_b[g]),
                .optical_data_in(optical_data_in[g]),
                .input_type_select(input_type_select_q[g]),
                .rx_code_field(rx_code_field_q[2*g +: 2]),
                .extended_zeros_select(extended_zeros_select_q[g]),
                .violation_compat_bit(violation_compat_bit_q),
                .tuned(tuned_q),
                .cnt_clear(cnt_clear_q[g]),
                .rx_data_q(rx_data[g]),
                .viol_q(rx_viol[g]),
                .cnt_q(cnt)
            );
            // Switch control registered
            always @(posedge clock) begin
                if (!rstn) begin
                    term_switch_on[g] <= 1'b0;
                    analog_switch_on[g] <= 1'b0;
                    osc_freq_sel[3*g +: 3] <= 3'h0;
                end else begin
                    osc_freq_sel[3*g +: 3] <= rs;
                    if (hw_term_assign_q[g]) begin
                        term_switch_on[g] <= eq & analog_switch_bit_q[g];
                        analog_switch_on[g] <= eq & (&analog_switch_enable_q);
                    end else begin
                        term_switch_on[g] <= termination_switch_bit_q[g];
                        analog_switch_on[g] <= analog_switch_bit_q[g] &
                            (&analog_switch_enable_q);
                    end
                end
            end
        end
    endgenerate
endmodule

/* verification/rld_checker.sv */
`timescale 1ns/10ps
////////////////////////////////////////
// Port-level relations of the receive line block
module rld_checker #(
    parameter NCH = 4
) (
    input wire clock,
    input wire rstn,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [NCH-1:0] recovered_clk_in,
    input wire [NCH-1:0] osc_clk_in,
    input wire [NCH-1:0] hw_termination_input,
    input wire [NCH-1:0] rx_viol,
    input wire [NCH-1:0] rx_clock_pin,
    input wire [NCH-1:0] term_switch_on,
    input wire [NCH-1:0] analog_switch_on,
    input wire [3*NCH-1:0] osc_freq_sel
);
    // A bus request is in flight
    wire req = avs_read | avs_write;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    a_wait_start: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("No wait cycle at start of access");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("Access not answered after one wait cycle");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h3C
        |-> avs_readdata == 32'h0) else $error("Unmapped read not zero");
    a_reset_quiet: assert property ($past(!rstn)
        |-> !(|{term_switch_on, analog_switch_on, rx_viol, osc_freq_sel}))
        else $error("Outputs active right after reset");
    a_switch_hold: assert property (
        (!avs_write && $stable(hw_termination_input)) [*3]
        |=> $stable({term_switch_on, analog_switch_on})) else $error("Switch moved without cause");
    a_pin_ones: assert property (
        (&recovered_clk_in) && (&osc_clk_in) |-> &rx_clock_pin) else $error("Clock pin not high");
    a_pin_zeros: assert property (
        !(|recovered_clk_in) && !(|osc_clk_in) |-> rx_clock_pin == 0) else $error("Clock pin high");
    a_freq_write: assert property (!$stable(osc_freq_sel) |->
        $past(avs_write && avs_address == 8'h04) || $past(avs_write && avs_address == 8'h04, 2))
        else $error("Oscillator select changed without a write");
    // Main scenarios
    c_read: cover property (avs_read && !avs_waitrequest);
    c_viol: cover property (|rx_viol);
    c_both: cover property ((|analog_switch_on) && (|term_switch_on));
endmodule

/* verification/rld_line_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////
// Far-end AMI sender: eight bursts of an 8-symbol pattern, spaces when idle
module rld_line_model (
    input wire clock,
    input wire rstn,
    input wire go,
    input wire [15:0] pattern,
    output reg busy,
    output reg [3:0] line_pos,
    output reg [3:0] line_neg,
    output reg [3:0] optical
);
    reg [5:0] idx_q; // Symbol index within the run
    wire [1:0] sym = pattern[15 - 2 * idx_q[2:0] -: 2]; // Positive, negative mark
    // One symbol per clock on every channel
    always @(posedge clock) begin
        if (!rstn) begin
            busy <= 1'b0;
            idx_q <= 6'h00;
            line_pos <= 4'h0;
            line_neg <= 4'h0;
            optical <= 4'h0;
        end else begin
            optical <= ~optical; // Unused optical lane never sits still
            line_pos <= busy ? {4{sym[1]}} : 4'h0;
            line_neg <= busy ? {4{sym[0]}} : 4'h0;
            idx_q <= busy ? idx_q + 6'h01 : 6'h00;
            if (go) begin
                busy <= 1'b1;
            end else if (idx_q == 6'h3F) begin
                busy <= 1'b0;
            end
        end
    end
endmodule

/* verification/rld_top_tb.sv */
`timescale 1ns/10ps
`include "rld_defines.vh"
////////////////////////////////////////
// Self-checking bench for the receive line block
module rld_top_tb;
    localparam NCH = 4;
    // Tuning series: high byte is the register offset, low byte the value
    localparam [15:0] TUNE [0:18] = '{16'h102C, 16'h14FF, 16'h10AC, 16'h102B, 16'h1400,
        16'h10AB, 16'h102A, 16'h14FF, 16'h10AA, 16'h1029, 16'h14FF, 16'h10A9, 16'h1028,
        16'h1400, 16'h10A8, 16'h1027, 16'h14FF, 16'h10A7, 16'h1000};
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [3:0] avs_byteenable = 4'hF;
    reg [3:0] rec = 4'h0, osc = 4'h0, hw = 4'h0; // Clock sources, termination level
    reg go = 1'b0;
    reg [15:0] pattern = 16'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, busy;
    wire [3:0] clk_pin, term_sw, analog_sw, line_pos, line_neg, optical;
    wire [11:0] osc_freq_sel;
    wire [3:0] rxd, rxv; // Decoded data and violation pulses
    integer nv = 0, nd = 0; // Running counts of channel 0 pulses and ones
    reg [31:0] exp_q [$]; // Expected read data, oldest first
    reg [31:0] r = 32'hC459B25D; // Random state
    integer n_errors = 0, checks_done = 0, cycles = 0, i;
    reg [3:0] t, a, en, as, et, ea;
    rld_top #(.NCH(NCH)) rld_top_inst (.clock(clock), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ternary_in_a(line_pos), .ternary_in_b(line_neg),
        .optical_data_in(optical), .recovered_clk_in(rec), .osc_clk_in(osc),
        .hw_termination_input(hw), .rx_data(rxd), .rx_viol(rxv), .rx_clock_pin(clk_pin),
        .term_switch_on(term_sw), .analog_switch_on(analog_sw), .osc_freq_sel(osc_freq_sel));
    rld_line_model rld_line_model_inst (.clock(clock), .rstn(rstn), .go(go), .pattern(pattern),
        .busy(busy), .line_pos(line_pos), .line_neg(line_neg), .optical(optical));
    initial forever #20 clock = ~clock;
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task check_rd(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task check_pin(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: outputs %h expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////
    // One bus access, held until waitrequest is seen low
    task bus(input wr, input [7:0] ad, input [31:0] d, input [3:0] be);
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input [7:0] ad, input [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, ad, 32'h0, 4'hF);
    endtask
    // Pattern burst, then time for the decoder to settle
    task send(input [15:0] p);
        pattern <= p;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        while (busy === 1'b1) @(posedge clock);
        repeat (8) @(posedge clock);
    endtask
    // Prime the line state, clear counters, send again and read every channel
    task run(input [15:0] p, input [15:0] e, input integer ed);
        integer c, bv, bd;
        send(p);
        bus(1'b1, `RLD_OFF_CMD, 32'h00000F00, 4'h2);
        bv = nv;
        bd = nd;
        send(p);
        check_pin(nv - bv, e);
        check_pin(nd - bd, ed);
        for (c = 0; c < 4; c = c + 1) rd(`RLD_OFF_CNT0 + 8'(4 * c), {16'h0, e});
    endtask
    task results;
        if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Tally violation pulses and decoded ones on channel 0
    always @(posedge clock) begin
        nv <= nv + rxv[0];
        nd <= nd + rxd[0];
    end
    // Each completed read meets the oldest note
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors = n_errors + 1;
            results;
        end
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) n_errors = n_errors + 1;
            else check_rd(avs_readdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(`RLD_OFF_CODE, 32'h010000FF);
        rd(8'h3C, 32'h0);
        bus(1'b1, 8'h3C, 32'hFFFFFFFF, 4'hF);
        rd(8'h3C, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            r = lfsr(r);
            t = i[3:0];
            bus(1'b1, `RLD_OFF_CODE, {7'h0, r[24], 4'h0, r[19:16], 4'h0, r[11:8], {4{t[1:0]}}}, 4'hF);
            rd(`RLD_OFF_CODE, {7'h0, r[24], 4'h0, r[19:16], 4'h0, r[11:8], {4{t[1:0]}}});
        end
        bus(1'b1, `RLD_OFF_CLK, 32'h04190A08, 4'hF);
        @(posedge clock);
        check_pin(osc_freq_sel, 12'hA08);
        for (i = 0; i < 12; i = i + 1) begin
            r = lfsr(r);
            rec <= i < 2 ? {4{i[0]}} : r[3:0];
            osc <= i < 2 ? {4{i[0]}} : r[7:4];
            @(negedge clock);
            check_pin(clk_pin, {rec[2], rec[0], osc[3], osc[1]});
            @(posedge clock);
        end
        for (i = 0; i < 12; i = i + 1) begin
            r = lfsr(r);
            {as, en, a, t} = {r[19:16], r[8] ? 4'hF : r[15:12], r[7:4], r[3:0]};
            hw <= r[23:20];
            bus(1'b1, `RLD_OFF_TERM, {4'h0, as, 4'h0, en, 4'h0, a, 4'h0, t}, 4'hF);
            et = (as & ~(t ^ hw) & a) | (~as & t);
            ea = ((as & ~(t ^ hw)) | (~as & a)) & {4{&en}};
            @(posedge clock);
            check_pin(term_sw, et);
            check_pin(analog_sw, ea);
            rd(`RLD_OFF_STAT, {16'h0, ea, et, 8'h00});
        end
        bus(1'b1, `RLD_OFF_CODE, 32'h010000AA, 4'hF);
        run(16'h8840, 16'd8, 24);
        run(16'h00A1, 16'd0, 16);
        bus(1'b1, `RLD_OFF_CODE, 32'h000000AA, 4'hF);
        for (i = 0; i < 19; i = i + 1) bus(1'b1, TUNE[i][15:8], {24'h0, TUNE[i][7:0]}, 4'hF);
        rd(`RLD_OFF_STAT, {16'h0, ea, et, 8'h01});
        run(16'h00A1, 16'd8, 24);
        bus(1'b1, `RLD_OFF_CMD, 32'h0000000F, 4'h1);
        rd(`RLD_OFF_STAT, {16'h0, ea, et, 8'h00});
        run(16'h00A1, 16'd0, 16);
        results;
    end
endmodule
bind rld_top rld_checker #(.NCH(NCH)) rld_checker_inst (.clock(clock), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .recovered_clk_in(recovered_clk_in), .osc_clk_in(osc_clk_in),
    .hw_termination_input(hw_termination_input), .rx_viol(rx_viol),
    .rx_clock_pin(rx_clock_pin), .term_switch_on(term_switch_on),
    .analog_switch_on(analog_switch_on), .osc_freq_sel(osc_freq_sel));
